// *** core/fwl_pkg.sv ***
// Purpose: Shared constants for the flash write/erase lock-key block
// Assumes: APB slave with 32-bit data, 100 MHz pclk
// Notes: Byte addresses of all registers are listed here
package fwl_pkg;
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_KEY = 12'h004;
  localparam logic [11:0] OFF_MOVE = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
  localparam logic [11:0] OFF_SUPPLY = 12'h018;
  localparam int CTRL_WE_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int SUP_EN_BIT = 0;
  localparam int SUP_RST_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LOCK_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int WRITE_TIME_NS = 20000;
  localparam int ERASE_TIME_NS = 40000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;
  localparam logic [1:0] RST_PULSE_CYCLES = 2'h3;
  typedef enum logic [3:0] {
    KEY_IDLE = 4'b0001,
    KEY_ONE = 4'b0010,
    KEY_OPEN = 4'b0100,
    KEY_LOCKED = 4'b1000
  } fwl_key_t;
endpackage

// *** core/fwl_key_fsm.sv ***
// Purpose: Two-step key state machine arming one flash operation
// Assumes: Strobes are single-cycle pulses on pclk
// Notes: Lockout is left only by presetn
`timescale 1ns/1ps
module fwl_key_fsm (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic op_attempt,
  output logic unlocked,
  output logic locked_out,
  output logic [1:0] key_state
);
  fwl_pkg::fwl_key_t state_r;
  fwl_pkg::fwl_key_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fwl_pkg::KEY_IDLE: begin
        if (op_attempt) begin
          state_nxt = fwl_pkg::KEY_LOCKED;
        end else if (key_wr) begin
          state_nxt = (key_data == fwl_pkg::KEY_FIRST) ?
                      fwl_pkg::KEY_ONE : fwl_pkg::KEY_LOCKED;
        end
      end
      fwl_pkg::KEY_ONE: begin
        if (op_attempt) begin
          state_nxt = fwl_pkg::KEY_LOCKED;
        end else if (key_wr) begin
          state_nxt = (key_data == fwl_pkg::KEY_SECOND) ?
                      fwl_pkg::KEY_OPEN : fwl_pkg::KEY_LOCKED;
        end
      end
      fwl_pkg::KEY_OPEN: begin
        // A further key write while armed counts as out of order
        if (key_wr) begin
          state_nxt = fwl_pkg::KEY_LOCKED;
        end else if (op_attempt) begin
          state_nxt = fwl_pkg::KEY_IDLE;
        end
      end
      fwl_pkg::KEY_LOCKED: begin
        state_nxt = fwl_pkg::KEY_LOCKED;
      end
      default: begin
        state_nxt = fwl_pkg::KEY_LOCKED;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= fwl_pkg::KEY_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign unlocked = (state_r == fwl_pkg::KEY_OPEN);
  assign locked_out = (state_r == fwl_pkg::KEY_LOCKED);
  always_comb begin
    unique case (state_r)
      fwl_pkg::KEY_IDLE: key_state = 2'h0;
      fwl_pkg::KEY_ONE: key_state = 2'h1;
      fwl_pkg::KEY_OPEN: key_state = 2'h2;
      default: key_state = 2'h3;
    endcase
  end

  property p_lock_sticky;
    @(posedge pclk) disable iff (!presetn)
    locked_out |=> locked_out;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("Lockout left without reset");

  property p_bad_first;
    @(posedge pclk) disable iff (!presetn)
    (state_r == fwl_pkg::KEY_IDLE && key_wr && !op_attempt &&
     key_data != fwl_pkg::KEY_FIRST) |=> locked_out;
  endproperty
  a_bad_first: assert property (p_bad_first)
    else $error("Wrong first key did not lock");

  property p_early_op;
    @(posedge pclk) disable iff (!presetn)
    (!unlocked && op_attempt) |=> locked_out;
  endproperty
  a_early_op: assert property (p_early_op)
    else $error("Operation before keys did not lock");

  property p_rearm;
    @(posedge pclk) disable iff (!presetn)
    (unlocked && op_attempt && !key_wr) |=> !unlocked && !locked_out;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("Lock did not re-arm after operation");

  property p_two_keys;
    @(posedge pclk) disable iff (!presetn)
    $rose(unlocked) |-> $past(key_wr) &&
      $past(key_data) == fwl_pkg::KEY_SECOND;
  endproperty
  a_two_keys: assert property (p_two_keys)
    else $error("Unlocked without second key");
endmodule

// *** core/fwl_flash_mem.sv ***
// Purpose: Flash array model with program-clears and erase-sets bits
// Assumes: One operation at a time, strobed for one cycle
// Notes: Erase sets every byte of the page the address falls in to all ones
`timescale 1ns/1ps
module fwl_flash_mem #(
  parameter int ADDR_W = 8,
  parameter int PAGE_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic prog_stb,
  input wire logic erase_stb,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem_r [2**ADDR_W];

  // Array holds its contents through reset, like real flash
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      if (erase_stb && (i >> PAGE_W) == int'(addr >> PAGE_W)) begin
        mem_r[i] <= fwl_pkg::ERASED_BYTE;
      end
    end
    if (prog_stb) begin
      mem_r[addr] <= mem_r[addr] & wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_r[addr];
    end
  end

  property p_prog_and;
    @(posedge pclk) disable iff (!presetn)
    prog_stb |=> mem_r[$past(addr)] == ($past(mem_r[addr]) & $past(wdata));
  endproperty
  a_prog_and: assert property (p_prog_and)
    else $error("Program set a bit back to one");

  property p_erase_ones;
    @(posedge pclk) disable iff (!presetn)
    erase_stb |=> mem_r[$past(addr)] == fwl_pkg::ERASED_BYTE;
  endproperty
  a_erase_ones: assert property (p_erase_ones)
    else $error("Erase left a byte not all ones");
endmodule

// *** core/fwl_top.sv ***
// Purpose: APB-controlled flash write/erase sequencer with lock and key
// Assumes: APB master holds requests until pready; pclk at 100 MHz
// Notes: Key check and flash array live in the two child modules
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module fwl_top #(
  parameter int ADDR_W = 8,
  parameter int PAGE_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_move_wr,
  input wire logic [15:0] ext_move_addr,
  input wire logic [7:0] ext_move_data,
  output logic data_mem_wr,
  output logic [15:0] data_mem_addr,
  output logic [7:0] data_mem_data,
  input wire logic flash_initialized,
  input wire logic debug_port_prog,
  output logic cpu_stall,
  output logic flash_error_reset,
  output logic irq
);
  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_PROG = 3'b010,
    OP_ERASE = 3'b100
  } fwl_op_t;

  fwl_op_t op_r;
  logic [fwl_pkg::TIMER_W-1:0] timer_r;
  logic we_r;
  logic erase_sel_r;
  logic sup_en_r;
  logic sup_rst_r;
  logic [fwl_pkg::IRQ_W-1:0] irq_stat_r;
  logic [fwl_pkg::IRQ_W-1:0] irq_mask_r;
  logic [1:0] err_cnt_r;
  logic [ADDR_W-1:0] op_addr_r;
  logic [7:0] op_data_r;
  logic [7:0] flash_rdata;
  logic unlocked;
  logic locked_out;
  logic [1:0] key_state;
  logic wr_acc;
  logic rd_acc;
  logic key_wr;
  logic move_stb;
  logic apb_move;
  logic cpu_move;
  logic flash_req;
  logic op_attempt;
  logic op_start;
  logic op_done;
  logic supply_bad;
  logic sw_allowed;
  logic [15:0] req_addr;
  logic [7:0] req_data;
  logic [fwl_pkg::TIMER_W-1:0] stall_cnt_r;
  logic locked_d_r;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // Always ready in the access phase: zero wait states
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pslverr = psel && penable && !(hit(paddr, fwl_pkg::OFF_CTRL) ||
    hit(paddr, fwl_pkg::OFF_KEY) || hit(paddr, fwl_pkg::OFF_MOVE) ||
    hit(paddr, fwl_pkg::OFF_STATUS) || hit(paddr, fwl_pkg::OFF_IRQ_STAT) ||
    hit(paddr, fwl_pkg::OFF_IRQ_MASK) || hit(paddr, fwl_pkg::OFF_SUPPLY));

  assign key_wr = wr_acc && hit(paddr, fwl_pkg::OFF_KEY);
  assign apb_move = wr_acc && hit(paddr, fwl_pkg::OFF_MOVE);
  // Moves from the core are ignored while it is stalled
  assign cpu_move = ext_move_wr && op_r == OP_IDLE;
  assign move_stb = apb_move || cpu_move;
  assign req_addr = cpu_move ? ext_move_addr : pwdata[23:8];
  assign req_data = cpu_move ? ext_move_data : pwdata[7:0];
  // Uninitialized flash is reserved for the debug port
  assign sw_allowed = flash_initialized && !debug_port_prog;
  assign flash_req = move_stb && we_r && sw_allowed;
  assign supply_bad = !sup_en_r || !sup_rst_r;
  // A locked-out request is a silent no-op
  assign op_attempt = flash_req && !supply_bad && !locked_out;
  assign op_start = op_attempt && unlocked && op_r == OP_IDLE;
  assign op_done = op_r != OP_IDLE && timer_r == '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_mem_wr <= 1'b0;
      data_mem_addr <= 16'h0000;
      data_mem_data <= 8'h00;
    end else begin
      data_mem_wr <= move_stb && !we_r;
      if (move_stb && !we_r) begin
        data_mem_addr <= req_addr;
        data_mem_data <= req_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_r <= 1'b0;
      erase_sel_r <= 1'b0;
    end else if (wr_acc && hit(paddr, fwl_pkg::OFF_CTRL)) begin
      we_r <= pwdata[fwl_pkg::CTRL_WE_BIT];
      erase_sel_r <= pwdata[fwl_pkg::CTRL_ERASE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_en_r <= 1'b0;
      sup_rst_r <= 1'b0;
    end else if (wr_acc && hit(paddr, fwl_pkg::OFF_SUPPLY)) begin
      sup_en_r <= pwdata[fwl_pkg::SUP_EN_BIT];
      sup_rst_r <= pwdata[fwl_pkg::SUP_RST_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= OP_IDLE;
      timer_r <= '0;
      op_addr_r <= '0;
      op_data_r <= 8'h00;
    end else begin
      unique case (op_r)
        OP_IDLE: begin
          if (op_start) begin
            op_addr_r <= req_addr[ADDR_W-1:0];
            op_data_r <= req_data;
            if (erase_sel_r) begin
              op_r <= OP_ERASE;
              timer_r <= fwl_pkg::TIMER_W'(fwl_pkg::ERASE_CYCLES - 1);
            end else begin
              op_r <= OP_PROG;
              timer_r <= fwl_pkg::TIMER_W'(fwl_pkg::WRITE_CYCLES - 1);
            end
          end
        end
        OP_PROG, OP_ERASE: begin
          if (timer_r == '0) begin
            op_r <= OP_IDLE;
          end else begin
            timer_r <= timer_r - 1'b1;
          end
        end
        default: begin
          op_r <= OP_IDLE;
        end
      endcase
    end
  end

  assign cpu_stall = op_r != OP_IDLE;

  // Check helper: stalled cycles so far, too long for a repetition count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_r <= '0;
    end else if (cpu_stall) begin
      stall_cnt_r <= stall_cnt_r + 1'b1;
    end else begin
      stall_cnt_r <= '0;
    end
  end

  // Flash error reset pulse lasts a few cycles so the reset net sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt_r <= 2'h0;
    end else if (flash_req && supply_bad) begin
      err_cnt_r <= fwl_pkg::RST_PULSE_CYCLES;
    end else if (err_cnt_r != 2'h0) begin
      err_cnt_r <= err_cnt_r - 2'h1;
    end
  end
  assign flash_error_reset = err_cnt_r != 2'h0;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      locked_d_r <= 1'b0;
    end else begin
      // Lock event is the entry into lockout, not every key write
      locked_d_r <= locked_out;
      for (int i = 0; i < fwl_pkg::IRQ_W; i++) begin
        if ((i == fwl_pkg::IRQ_DONE_BIT && op_done) ||
            (i == fwl_pkg::IRQ_LOCK_BIT && locked_out && !locked_d_r)) begin
          irq_stat_r[i] <= 1'b1;
        end else if (wr_acc && hit(paddr, fwl_pkg::OFF_IRQ_STAT) &&
                     pwdata[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
      if (wr_acc && hit(paddr, fwl_pkg::OFF_IRQ_MASK)) begin
        irq_mask_r <= pwdata[fwl_pkg::IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      if (hit(paddr, fwl_pkg::OFF_CTRL)) begin
        prdata = {30'h0, erase_sel_r, we_r};
      end else if (hit(paddr, fwl_pkg::OFF_MOVE)) begin
        prdata = {24'h0, flash_rdata};
      end else if (hit(paddr, fwl_pkg::OFF_STATUS)) begin
        prdata = {27'h0, cpu_stall, locked_out, unlocked, key_state};
      end else if (hit(paddr, fwl_pkg::OFF_IRQ_STAT)) begin
        prdata = {30'h0, irq_stat_r};
      end else if (hit(paddr, fwl_pkg::OFF_IRQ_MASK)) begin
        prdata = {30'h0, irq_mask_r};
      end else if (hit(paddr, fwl_pkg::OFF_SUPPLY)) begin
        prdata = {30'h0, sup_rst_r, sup_en_r};
      end
    end
  end

  fwl_key_fsm u_key (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(key_wr),
    .key_data(pwdata[7:0]),
    .op_attempt(op_attempt),
    .unlocked(unlocked),
    .locked_out(locked_out),
    .key_state(key_state)
  );

  fwl_flash_mem #(
    .ADDR_W(ADDR_W),
    .PAGE_W(PAGE_W)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .prog_stb(op_done && op_r == OP_PROG),
    .erase_stb(op_done && op_r == OP_ERASE),
    .addr(op_r == OP_IDLE ? pwdata[8+ADDR_W-1:8] : op_addr_r),
    .wdata(op_data_r),
    .rdata(flash_rdata)
  );

  property p_stall_len;
    @(posedge pclk) disable iff (!presetn)
    (op_start && !erase_sel_r) |=> cpu_stall [*8];
  endproperty
  a_stall_len: assert property (p_stall_len)
    else $error("Stall dropped early during program");

  property p_done_bound;
    @(posedge pclk) disable iff (!presetn)
    (op_r == OP_PROG) |-> int'(stall_cnt_r) < fwl_pkg::WRITE_CYCLES;
  endproperty
  a_done_bound: assert property (p_done_bound)
    else $error("Program did not finish in time");

  property p_we_kept;
    @(posedge pclk) disable iff (!presetn)
    (we_r && !(wr_acc && hit(paddr, fwl_pkg::OFF_CTRL))) |=> we_r;
  endproperty
  a_we_kept: assert property (p_we_kept)
    else $error("Write enable cleared by hardware");

  property p_err_rst;
    @(posedge pclk) disable iff (!presetn)
    (flash_req && supply_bad) |=> flash_error_reset [*3];
  endproperty
  a_err_rst: assert property (p_err_rst)
    else $error("Missing flash error reset");

  property p_redirect;
    @(posedge pclk) disable iff (!presetn)
    (move_stb && we_r) |=> !data_mem_wr;
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("Move reached data memory while enabled");

  property p_erase_bound;
    @(posedge pclk) disable iff (!presetn)
    (op_r == OP_ERASE) |-> int'(stall_cnt_r) < fwl_pkg::ERASE_CYCLES;
  endproperty
  a_erase_bound: assert property (p_erase_bound)
    else $error("Erase did not finish in time");

  property p_prog_len;
    @(posedge pclk) disable iff (!presetn)
    (op_done && op_r == OP_PROG) |->
      int'(stall_cnt_r) == fwl_pkg::WRITE_CYCLES - 1;
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("Program stall length wrong");

  property p_erase_len;
    @(posedge pclk) disable iff (!presetn)
    (op_done && op_r == OP_ERASE) |->
      int'(stall_cnt_r) == fwl_pkg::ERASE_CYCLES - 1;
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("Erase stall length wrong");

  property p_supply_block;
    @(posedge pclk) disable iff (!presetn)
    (supply_bad && !cpu_stall) |=> !cpu_stall;
  endproperty
  a_supply_block: assert property (p_supply_block)
    else $error("Operation started with supply monitor off");

  property p_blank_block;
    @(posedge pclk) disable iff (!presetn)
    ((!flash_initialized || debug_port_prog) && !cpu_stall) |=> !cpu_stall;
  endproperty
  a_blank_block: assert property (p_blank_block)
    else $error("Software operation on reserved flash");

  property p_lock_noop;
    @(posedge pclk) disable iff (!presetn)
    (locked_out && !cpu_stall) |=> !cpu_stall;
  endproperty
  a_lock_noop: assert property (p_lock_noop)
    else $error("Operation started while locked out");

  property p_lock_irq;
    @(posedge pclk) disable iff (!presetn)
    $rose(locked_out) |=> irq_stat_r[fwl_pkg::IRQ_LOCK_BIT];
  endproperty
  a_lock_irq: assert property (p_lock_irq)
    else $error("Lockout did not flag its event");
endmodule

// *** testbench/fwl_core_model.sv ***
// Purpose: Processor core model issuing external data move writes
// Assumes: Moves are single-cycle pulses launched after a rising edge
// Notes: Released operands are inverted so stale values never look valid
`timescale 1ns/1ps
module fwl_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_stall,
  output logic ext_move_wr,
  output logic [15:0] ext_move_addr,
  output logic [7:0] ext_move_data
);
  initial begin
    ext_move_wr = 1'b0;
    ext_move_addr = 16'h0000;
    ext_move_data = 8'h00;
  end
  // Gap models a slow core; a stalled core executes nothing
  task automatic move(input logic [15:0] a, input logic [7:0] d,
                      input int gap);
    repeat (gap) @(posedge pclk);
    while (cpu_stall === 1'b1 || presetn !== 1'b1) @(posedge pclk);
    ext_move_wr <= 1'b1;
    ext_move_addr <= a;
    ext_move_data <= d;
    @(posedge pclk);
    ext_move_wr <= 1'b0;
    ext_move_addr <= ~a;
    ext_move_data <= ~d;
  endtask
endmodule

// *** testbench/fwl_top_tb_top.sv ***
// Purpose: Self-checking bench for the flash lock-key sequencer
// Assumes: Zero-wait APB slave, program 2000 and erase 4000 cycles
// Notes: Flash is erased before any byte is read back
`timescale 1ns/1ps
module fwl_top_tb_top;
  typedef struct {
    logic [11:0] a;
    logic [31:0] wd;
    logic [31:0] ex;
    logic er;
  } fwl_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ext_move_wr, data_mem_wr, flash_initialized, debug_port_prog;
  logic [15:0] ext_move_addr, data_mem_addr, dm_addr;
  logic [7:0] ext_move_data, data_mem_data, dm_data;
  logic cpu_stall, flash_error_reset, irq, er;
  int n_mismatch = 0;
  int tests_run = 0;
  int dm_cnt = 0;
  int n;
  fwl_row_t rows [4] = '{
    '{fwl_pkg::OFF_CTRL, 32'h2, 32'h2, 1'b0},
    '{fwl_pkg::OFF_IRQ_MASK, 32'h3, 32'h3, 1'b0},
    '{fwl_pkg::OFF_SUPPLY, 32'h2, 32'h2, 1'b0},
    '{12'h01c, 32'h5, 32'h0, 1'b1}};

  fwl_top u_fwl_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_move_wr(ext_move_wr), .ext_move_addr(ext_move_addr),
    .ext_move_data(ext_move_data), .data_mem_wr(data_mem_wr),
    .data_mem_addr(data_mem_addr), .data_mem_data(data_mem_data),
    .flash_initialized(flash_initialized),
    .debug_port_prog(debug_port_prog), .cpu_stall(cpu_stall),
    .flash_error_reset(flash_error_reset), .irq(irq));
  fwl_core_model u_fwl_core_model (.pclk(pclk), .presetn(presetn),
    .cpu_stall(cpu_stall), .ext_move_wr(ext_move_wr),
    .ext_move_addr(ext_move_addr), .ext_move_data(ext_move_data));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (data_mem_wr === 1'b1) begin
    dm_cnt++;
    dm_addr = data_mem_addr;
    dm_data = data_mem_data;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic keys();
    apb(1'b1, fwl_pkg::OFF_KEY, {24'h0, fwl_pkg::KEY_FIRST});
    apb(1'b1, fwl_pkg::OFF_KEY, {24'h0, fwl_pkg::KEY_SECOND});
  endtask
  task automatic flash_rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, fwl_pkg::OFF_MOVE, {16'h0, a, 8'h00});
    chk("flash byte", {24'h0, rd[7:0]}, {24'h0, e});
  endtask
  task automatic status(input logic [31:0] e);
    apb(1'b0, fwl_pkg::OFF_STATUS, 32'h0);
    chk("status", rd, e);
  endtask
  // Stall must come within a few edges and last the exact count
  task automatic wait_op(input int e);
    int k, c;
    k = 0;
    c = 0;
    #1;
    while (cpu_stall !== 1'b1 && k < 10) begin
      @(posedge pclk);
      #1;
      k++;
    end
    while (cpu_stall === 1'b1 && c < 5000) begin
      @(posedge pclk);
      #1;
      c++;
    end
    chk("stall cycles", c, e);
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    flash_initialized = 1'b1;
    debug_port_prog = 1'b0;
    do_reset();
    status(32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      chk("slave error", {31'h0, er}, {31'h0, rows[i].er});
      if (!rows[i].er) chk("register", rd, rows[i].ex);
    end
    chk("ready", {31'h0, pready}, 32'h1);
    apb(1'b1, fwl_pkg::OFF_CTRL, 32'h0);
    u_fwl_core_model.move(16'h1234, 8'h5a, 0);
    repeat (2) @(posedge pclk);
    chk("data move", {dm_cnt[7:0], dm_addr, dm_data}, 32'h01_1234_5a);
    apb(1'b1, fwl_pkg::OFF_SUPPLY, 32'h1);
    apb(1'b1, fwl_pkg::OFF_SUPPLY, 32'h3);
    apb(1'b1, fwl_pkg::OFF_CTRL, 32'h3);
    apb(1'b1, fwl_pkg::OFF_KEY, {24'h0, fwl_pkg::KEY_FIRST});
    status(32'h01);
    apb(1'b1, fwl_pkg::OFF_KEY, {24'h0, fwl_pkg::KEY_SECOND});
    status(32'h06);
    u_fwl_core_model.move(16'h0003, 8'h00, 3);
    wait_op(fwl_pkg::ERASE_CYCLES);
    chk("no data move", dm_cnt, 1);
    flash_rd(8'h00, fwl_pkg::ERASED_BYTE);
    flash_rd(8'h0f, fwl_pkg::ERASED_BYTE);
    status(32'h0);
    apb(1'b0, fwl_pkg::OFF_CTRL, 32'h0);
    chk("write enable kept", rd, 32'h3);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, fwl_pkg::OFF_IRQ_MASK, 32'h0);
    #1;
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, fwl_pkg::OFF_IRQ_STAT, 32'h1);
    apb(1'b0, fwl_pkg::OFF_IRQ_STAT, 32'h0);
    chk("irq cleared", rd, 32'h0);
    apb(1'b1, fwl_pkg::OFF_IRQ_MASK, 32'h3);
    apb(1'b1, fwl_pkg::OFF_CTRL, 32'h1);
    keys();
    apb(1'b1, fwl_pkg::OFF_MOVE, 32'h0000_053c);
    wait_op(fwl_pkg::WRITE_CYCLES);
    flash_rd(8'h05, 8'h3c);
    keys();
    u_fwl_core_model.move(16'h0005, 8'hf0, 0);
    wait_op(fwl_pkg::WRITE_CYCLES);
    flash_rd(8'h05, 8'h30);
    apb(1'b1, fwl_pkg::OFF_IRQ_STAT, 32'h3);
    u_fwl_core_model.move(16'h0005, 8'h00, 0);
    wait_op(0);
    status(32'h0b);
    chk("lock irq", {31'h0, irq}, 32'h1);
    keys();
    status(32'h0b);
    u_fwl_core_model.move(16'h0005, 8'h00, 0);
    wait_op(0);
    flash_rd(8'h05, 8'h30);
    do_reset();
    apb(1'b1, fwl_pkg::OFF_SUPPLY, 32'h1);
    apb(1'b1, fwl_pkg::OFF_CTRL, 32'h1);
    keys();
    u_fwl_core_model.move(16'h0006, 8'h00, 0);
    n = 0;
    #1;
    repeat (8) begin
      if (flash_error_reset === 1'b1) n++;
      @(posedge pclk);
      #1;
    end
    chk("error reset cycles", n, 3);
    chk("no stall", {31'h0, cpu_stall}, 32'h0);
    status(32'h06);
    do_reset();
    apb(1'b1, fwl_pkg::OFF_KEY, {24'h0, fwl_pkg::KEY_FIRST});
    apb(1'b1, fwl_pkg::OFF_KEY, 32'h12);
    status(32'h0b);
    do_reset();
    apb(1'b1, fwl_pkg::OFF_KEY, {24'h0, fwl_pkg::KEY_SECOND});
    status(32'h0b);
    do_reset();
    flash_initialized <= 1'b0;
    apb(1'b1, fwl_pkg::OFF_SUPPLY, 32'h3);
    apb(1'b1, fwl_pkg::OFF_CTRL, 32'h1);
    keys();
    u_fwl_core_model.move(16'h0007, 8'h00, 0);
    wait_op(0);
    status(32'h06);
    flash_initialized <= 1'b1;
    debug_port_prog <= 1'b1;
    u_fwl_core_model.move(16'h0007, 8'h00, 0);
    wait_op(0);
    status(32'h06);
    debug_port_prog <= 1'b0;
    u_fwl_core_model.move(16'h0007, 8'h81, 0);
    wait_op(fwl_pkg::WRITE_CYCLES);
    flash_rd(8'h07, 8'h81);
    finish_test();
  end
endmodule
